// ===== core/gain_step_ctrl.sv
// Automatic gain controller: steps the three stage gains on level samples.
// Assumes level samples and the preamble flag are synchronous to clk.
`timescale 1ns/1ps
module gain_step_ctrl
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic ce,
	input wire radio_cfg_pkg::gain_step_cfg_t cfg,
	input wire radio_cfg_pkg::gain_ctrl_op_mode_t mode,
	input wire radio_cfg_pkg::gain_set_t manual_gain,
	input wire logic [7:0] low_threshold,
	input wire logic [7:0] high_threshold,
	input wire logic [7:0] level,
	input wire logic level_valid,
	input wire logic preamble_qualified,
	output radio_cfg_pkg::gain_set_t applied_gain,
	output logic extra_low_active
);
	import radio_cfg_pkg::*;
	`include "radio_cfg_defines.svh"

	typedef struct packed
	{
		gain_set_t g;
		logic xlow;
		logic locked;
	} agc_state_t;

	agc_state_t s;
	agc_state_t next_s;

	// Step logic; step down walks the order upward, step up walks it back
	always_comb
	begin
		gain_set_t cand;
		logic cand_x;
		logic done;
		cand = s.g;
		cand_x = s.xlow;
		done = 1'b0;
		next_s = s;
		if (mode != MODE_LOCK)
			next_s.locked = 1'b0;
		else if (preamble_qualified)
			next_s.locked = 1'b1;
		if (mode == MODE_MANUAL)
		begin
			next_s.g = manual_gain;
			next_s.xlow = 1'b0;
		end
		else if (mode != MODE_HOLD && !(mode == MODE_LOCK && s.locked) && level_valid)
		begin
			if (level > high_threshold)
			begin
				for (int p = 0; p < 4; p++)
				begin
					if (!done && cfg.front_amp_step_order == 2'(p))
					begin
						if (cand.front_amp != 2'h0)
						begin
							cand.front_amp = cand.front_amp - 2'h1;
							done = 1'b1;
						end
						else if (cfg.allow_extra_low_amp_gain && !cand_x)
						begin
							cand_x = 1'b1;
							done = 1'b1;
						end
					end
					if (!done && cfg.mixer_step_order == 2'(p) && cand.mixer)
					begin
						cand.mixer = 1'b0;
						done = 1'b1;
					end
					if (!done && cfg.filter_step_order == 2'(p) && cand.filter != 2'h0)
					begin
						cand.filter = cand.filter - 2'h1;
						done = 1'b1;
					end
				end
			end
			else if (level < low_threshold)
			begin
				for (int p = 3; p >= 0; p--)
				begin
					if (!done && cfg.filter_step_order == 2'(p)
						&& cand.filter < `FILTER_GAIN_MAX)
					begin
						cand.filter = cand.filter + 2'h1;
						done = 1'b1;
					end
					if (!done && cfg.mixer_step_order == 2'(p) && !cand.mixer)
					begin
						cand.mixer = 1'b1;
						done = 1'b1;
					end
					if (!done && cfg.front_amp_step_order == 2'(p))
					begin
						if (cand_x)
						begin
							cand_x = 1'b0;
							done = 1'b1;
						end
						else if (cand.front_amp < `FRONT_AMP_GAIN_MAX)
						begin
							cand.front_amp = cand.front_amp + 2'h1;
							done = 1'b1;
						end
					end
				end
			end
			// Refuse a step that would land on the top overall gain
			if (!(cfg.disallow_max_gain && !cand_x && cand.front_amp == `FRONT_AMP_GAIN_MAX
				&& cand.mixer && cand.filter == `FILTER_GAIN_MAX))
			begin
				next_s.g = cand;
				next_s.xlow = cand_x;
			end
		end
		if (!cfg.allow_extra_low_amp_gain)
			next_s.xlow = 1'b0;
	end

	// State register, frozen while ce is low
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			s <= '0;
		else if (ce)
			s <= next_s;
	end

	assign applied_gain = s.g;
	assign extra_low_active = s.xlow;
endmodule

// ===== core/osc_cal_seq.sv
// Oscillator calibration sequencer, started on a transmit or receive entry while idle.
// Assumes the analog search results are stable by the end of the run.
`timescale 1ns/1ps
`include "radio_cfg_defines.svh"
module osc_cal_seq
#(
	parameter int CAL_CYCLES = `CAL_CYCLES
)
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic ce,
	input wire logic state_entry,
	input wire logic [3:0] osc_cal_setting,
	input wire logic [7:0] band_search,
	input wire logic [7:0] bias_search,
	output logic busy,
	output logic [7:0] band_result,
	output logic [7:0] bias_result
);
	import radio_cfg_pkg::*;

	typedef enum logic [1:0]
	{
		CAL_IDLE = 2'b01,
		CAL_RUN = 2'b10
	} cal_state_t;

	typedef struct packed
	{
		cal_state_t st;
		logic [15:0] cnt;
		logic [7:0] band;
		logic [7:0] bias;
	} cal_t;

	cal_t s;
	cal_t next_s;

	// Run on entry unless bypassed; results latch when the run ends
	always_comb
	begin
		next_s = s;
		unique case (s.st)
			CAL_IDLE:
			begin
				if (state_entry && osc_cal_setting != `CAL_SETTING_SKIP)
				begin
					next_s.st = CAL_RUN;
					next_s.cnt = 16'(CAL_CYCLES - 1);
				end
			end
			CAL_RUN:
			begin
				if (s.cnt == 16'h0000)
				begin
					next_s.st = CAL_IDLE;
					next_s.band = band_search;
					next_s.bias = bias_search;
				end
				else
					next_s.cnt = s.cnt - 16'h0001;
			end
			default:
				next_s.st = CAL_IDLE;
		endcase
	end

	// State register, frozen while ce is low
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			s.st <= CAL_IDLE;
			s.cnt <= 16'h0000;
			s.band <= 8'h00;
			s.bias <= 8'h00;
		end
		else if (ce)
			s <= next_s;
	end

	assign busy = (s.st == CAL_RUN);
	assign band_result = s.band;
	assign bias_result = s.bias;
endmodule

// ===== core/radio_cfg_defines.svh
// Register offsets, field constants, reset values and timing counts
// for the radio gain and oscillator configuration bank.
// Assumes a 100 MHz system clock and a 10-bit byte address.
`ifndef RADIO_CFG_DEFINES_SVH
`define RADIO_CFG_DEFINES_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define OFS_GAIN_STEP_CONFIG 10'h35C
`define OFS_GAIN_MODE_MANUAL 10'h35D
`define OFS_GAIN_LOW_THRESHOLD 10'h35E
`define OFS_GAIN_HIGH_THRESHOLD 10'h35F
`define OFS_APPLIED_GAIN_STATUS 10'h360
`define OFS_FREQ_OFFSET_READBACK 10'h372
`define OFS_OSC_BAND_OVERRIDE_VALUE 10'h3CB
`define OFS_OSC_BIAS_OVERRIDE_VALUE 10'h3CC
`define OFS_OSC_OVERRIDE_ENABLES 10'h3CD
`define OFS_OSC_CALIBRATION_CONFIG 10'h3D0
`define OFS_CRYSTAL_TRIM_CONFIG 10'h3D2
`define OFS_OSC_BAND_READBACK 10'h3DA

// ****************************************************************
// Reset values and field constants
// ****************************************************************
`define RST_GAIN_STEP_CONFIG 8'h9C
`define RST_GAIN_MODE_MANUAL 8'h00
`define RST_GAIN_LOW_THRESHOLD 8'h37
`define RST_GAIN_HIGH_THRESHOLD 8'h69
`define RST_OSC_CAL_SETTING 4'h1
`define CAL_SETTING_SKIP 4'hF
`define CAL_SETTING_RUN 4'h1
`define FRONT_AMP_GAIN_MAX 2'h2
`define FILTER_GAIN_MAX 2'h2

// ****************************************************************
// Timing
// ****************************************************************
`define CLK_PERIOD_NS 10
`define CAL_TIME_NS 2000
`define CAL_CYCLES ((`CAL_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ===== core/radio_cfg_pkg.sv
// Types shared by the radio gain and oscillator configuration bank.
// Holds no numbers beyond the mode encodings; the others live in radio_cfg_defines.svh.
package radio_cfg_pkg;

	// Gain-control operating modes
	typedef enum logic [1:0]
	{
		MODE_FREE = 2'h0,
		MODE_MANUAL = 2'h1,
		MODE_HOLD = 2'h2,
		MODE_LOCK = 2'h3
	} gain_ctrl_op_mode_t;

	// Gain of the three receive stages
	typedef struct packed
	{
		logic [1:0] front_amp;
		logic mixer;
		logic [1:0] filter;
	} gain_set_t;

	// Step ordering and limits of the gain controller
	typedef struct packed
	{
		logic [1:0] front_amp_step_order;
		logic [1:0] mixer_step_order;
		logic [1:0] filter_step_order;
		logic allow_extra_low_amp_gain;
		logic disallow_max_gain;
	} gain_step_cfg_t;

	// Register port request from software
	typedef struct packed
	{
		logic [9:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} reg_req_t;

endpackage

// ===== core/radio_gain_vco_cfg_regs.sv
// Radio gain-control and oscillator configuration register bank.
// Assumes a software port with one-cycle strobes, read data one cycle later,
// and that the demodulator, level meter and oscillator search share clk.
//
// Operation
// - Mode field 0 free, 1 manual, 2 hold, 3 freeze after qualified preamble.
// - Bits 7:6 place the front amplifier step; reset value 2.
// - Bits 5:4 place the mixer step; reset value 1.
// - Bits 3:2 place the filter step; reset value 3.
// - Bit 1 allows one extra, lower front amplifier gain.
// - Bit 0 forbids the highest overall gain; only controller steps onto it are refused, manual gain is applied as written.
// - Eight-bit read-only frequency offset, one unit per kHz.
// - The frequency offset reads as a signed two's complement value.
// - Band override enable substitutes the software band for the calibrated band.
// - Bias override enable drives the bias DAC from the software value.
// - Bits 5:2 set the oscillator level reference used in the Q phase.
// - Calibration setting 0xF skips calibration on transmit or receive entry.
// - Calibration setting 0x1, the reset value, calibrates on each entry made while no run is in progress.
// - Bits 5:3 set the crystal trim; other bits hold zero.
// - Read-only band value holds the calibration outcome once done.
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/1ps
`include "radio_cfg_defines.svh"
module radio_gain_vco_cfg_regs
#(
	parameter int CAL_CYCLES = `CAL_CYCLES
)
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic ce,
	input wire radio_cfg_pkg::reg_req_t req,
	output logic [7:0] rdata,
	input wire logic [7:0] signal_level,
	input wire logic signal_level_valid,
	input wire logic preamble_qualified,
	input wire logic [7:0] freq_error,
	input wire logic freq_error_valid,
	input wire logic transmit_state_entry,
	input wire logic receive_state_entry,
	input wire logic [7:0] band_search,
	input wire logic [7:0] bias_search,
	output radio_cfg_pkg::gain_set_t applied_gain,
	output logic extra_low_amp_active,
	output logic [7:0] osc_band,
	output logic [7:0] osc_bias,
	output logic [3:0] osc_q_phase_level_ref,
	output logic [2:0] crystal_cap_trim,
	output logic osc_cal_busy
);
	import radio_cfg_pkg::*;

	// ****************************************************************
	// State
	// ****************************************************************

	typedef struct packed
	{
		// Gain controller setup
		gain_step_cfg_t step_cfg;
		logic [1:0] op_mode;
		gain_set_t manual_gain;
		logic [7:0] low_threshold;
		logic [7:0] high_threshold;

		// Captured frequency offset
		logic signed [7:0] freq_offset;

		// Oscillator controls
		logic [7:0] band_override;
		logic [7:0] bias_override;
		logic [3:0] q_ref;
		logic bias_override_on;
		logic band_override_on;
		logic [3:0] cal_setting;
		logic [2:0] cap_trim;

		// Registered outputs and read data
		logic [7:0] band_out;
		logic [7:0] bias_out;
		logic [7:0] rdata;
	} regs_t;

	regs_t s;
	regs_t next_s;

	gain_set_t agc_gain;
	logic agc_xlow;
	logic cal_busy;
	logic [7:0] cal_band;
	logic [7:0] cal_bias;
	logic state_entry;

	// Either radio entry starts the same calibration sequence
	assign state_entry = transmit_state_entry | receive_state_entry;

	// ****************************************************************
	// Gain controller
	// ****************************************************************

	gain_step_ctrl u_gain
	(
		.clk(clk),
		.resetn(resetn),
		.ce(ce),
		.cfg(s.step_cfg),
		.mode(gain_ctrl_op_mode_t'(s.op_mode)),
		.manual_gain(s.manual_gain),
		.low_threshold(s.low_threshold),
		.high_threshold(s.high_threshold),
		.level(signal_level),
		.level_valid(signal_level_valid),
		.preamble_qualified(preamble_qualified),
		.applied_gain(agc_gain),
		.extra_low_active(agc_xlow)
	);

	// ****************************************************************
	// Oscillator calibration
	// ****************************************************************

	osc_cal_seq #(.CAL_CYCLES(CAL_CYCLES)) u_cal
	(
		.clk(clk),
		.resetn(resetn),
		.ce(ce),
		.state_entry(state_entry),
		.osc_cal_setting(s.cal_setting),
		.band_search(band_search),
		.bias_search(bias_search),
		.busy(cal_busy),
		.band_result(cal_band),
		.bias_result(cal_bias)
	);

	// ****************************************************************
	// Register writes, captures and read mux
	// ****************************************************************

	// Writes store only defined bits so reserved bits always read zero
	always_comb
	begin
		next_s = s;
		if (req.wr)
		begin
			unique case (req.addr)
				// Step ordering and gain limits
				`OFS_GAIN_STEP_CONFIG:
				begin
					next_s.step_cfg = gain_step_cfg_t'(req.wdata);
				end

				// Operating mode and manual gains
				`OFS_GAIN_MODE_MANUAL:
				begin
					next_s.op_mode = req.wdata[6:5];
					next_s.manual_gain = gain_set_t'(req.wdata[4:0]);
				end

				// Level thresholds of the gain controller
				`OFS_GAIN_LOW_THRESHOLD:
				begin
					next_s.low_threshold = req.wdata;
				end

				`OFS_GAIN_HIGH_THRESHOLD:
				begin
					next_s.high_threshold = req.wdata;
				end

				// Software band and bias values
				`OFS_OSC_BAND_OVERRIDE_VALUE:
				begin
					next_s.band_override = req.wdata;
				end

				`OFS_OSC_BIAS_OVERRIDE_VALUE:
				begin
					next_s.bias_override = req.wdata;
				end

				// Level reference and the two override enables
				`OFS_OSC_OVERRIDE_ENABLES:
				begin
					next_s.q_ref = req.wdata[5:2];
					next_s.bias_override_on = req.wdata[1];
					next_s.band_override_on = req.wdata[0];
				end

				// Calibration setting; 0xF bypasses the run
				`OFS_OSC_CALIBRATION_CONFIG:
				begin
					next_s.cal_setting = req.wdata[3:0];
				end

				// Only the trim field is stored, so the rest reads zero
				`OFS_CRYSTAL_TRIM_CONFIG:
				begin
					next_s.cap_trim = req.wdata[5:3];
				end

				default:
				begin
					// Read-only and unmapped offsets ignore writes
				end
			endcase
		end

		// Latest offset estimate from the demodulator, kept signed
		if (freq_error_valid)
			next_s.freq_offset = signed'(freq_error);

		// Override values win over the calibration outcome
		if (s.band_override_on)
			next_s.band_out = s.band_override;
		else
			next_s.band_out = cal_band;
		if (s.bias_override_on)
			next_s.bias_out = s.bias_override;
		else
			next_s.bias_out = cal_bias;

		// Read data stands for exactly the cycle after the strobe
		next_s.rdata = 8'h00;
		if (req.rd)
		begin
			unique case (req.addr)
				// Gain controller setup
				`OFS_GAIN_STEP_CONFIG:
				begin
					next_s.rdata = s.step_cfg;
				end

				`OFS_GAIN_MODE_MANUAL:
				begin
					next_s.rdata = {1'b0, s.op_mode, s.manual_gain};
				end

				`OFS_GAIN_LOW_THRESHOLD:
				begin
					next_s.rdata = s.low_threshold;
				end

				`OFS_GAIN_HIGH_THRESHOLD:
				begin
					next_s.rdata = s.high_threshold;
				end

				// Live readbacks; the gain is the applied one, not the manual field
				`OFS_APPLIED_GAIN_STATUS:
				begin
					next_s.rdata = {3'h0, agc_gain};
				end

				`OFS_FREQ_OFFSET_READBACK:
				begin
					next_s.rdata = s.freq_offset;
				end

				// Oscillator controls, reserved bits as zero
				`OFS_OSC_BAND_OVERRIDE_VALUE:
				begin
					next_s.rdata = s.band_override;
				end

				`OFS_OSC_BIAS_OVERRIDE_VALUE:
				begin
					next_s.rdata = s.bias_override;
				end

				`OFS_OSC_OVERRIDE_ENABLES:
				begin
					next_s.rdata = {2'h0, s.q_ref, s.bias_override_on, s.band_override_on};
				end

				`OFS_OSC_CALIBRATION_CONFIG:
				begin
					next_s.rdata = {4'h0, s.cal_setting};
				end

				`OFS_CRYSTAL_TRIM_CONFIG:
				begin
					next_s.rdata = {2'h0, s.cap_trim, 3'h0};
				end

				// Calibration outcome, ignoring any override
				`OFS_OSC_BAND_READBACK:
				begin
					next_s.rdata = cal_band;
				end

				default:
				begin
					next_s.rdata = 8'h00;
				end
			endcase
		end
	end

	// ****************************************************************
	// State register
	// ****************************************************************

	// All state freezes while ce is low, including pending read data
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			s.step_cfg <= gain_step_cfg_t'(`RST_GAIN_STEP_CONFIG);
			s.op_mode <= 2'h0;
			s.manual_gain <= '0;
			s.low_threshold <= `RST_GAIN_LOW_THRESHOLD;
			s.high_threshold <= `RST_GAIN_HIGH_THRESHOLD;
			s.freq_offset <= '0;
			s.band_override <= 8'h00;
			s.bias_override <= 8'h00;
			s.q_ref <= 4'h0;
			s.bias_override_on <= 1'b0;
			s.band_override_on <= 1'b0;
			s.cal_setting <= `RST_OSC_CAL_SETTING;
			s.cap_trim <= 3'h0;
			s.band_out <= 8'h00;
			s.bias_out <= 8'h00;
			s.rdata <= 8'h00;
		end
		else if (ce)
			s <= next_s;
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************

	// All come from flip-flops here or inside the two sub-blocks
	assign rdata = s.rdata;
	assign applied_gain = agc_gain;
	assign extra_low_amp_active = agc_xlow;
	assign osc_band = s.band_out;
	assign osc_bias = s.bias_out;
	assign osc_q_phase_level_ref = s.q_ref;
	assign crystal_cap_trim = s.cap_trim;
	assign osc_cal_busy = cal_busy;
endmodule

// ===== test/radio_gain_vco_cfg_regs_bench.sv
// Self-checking bench for the radio gain and oscillator register bank.
// Assumes the package and defines are compiled first; short calibration run.
`timescale 1ns/1ps
`include "radio_cfg_defines.svh"
module radio_gain_vco_cfg_regs_bench;
	import radio_cfg_pkg::*;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic ce = 1'b1;
	reg_req_t req = '0;
	logic [7:0] level = 8'h00;
	logic level_valid = 1'b0;
	logic preamble = 1'b0;
	logic [7:0] ferr = 8'h00;
	logic ferr_valid = 1'b0;
	logic tx_entry = 1'b0;
	logic rx_entry = 1'b0;
	logic [7:0] band_search = 8'h00;
	logic [7:0] bias_search = 8'h00;
	logic [7:0] rdata;
	logic [7:0] osc_band;
	logic [7:0] osc_bias;
	gain_set_t applied_gain;
	logic extra_low;
	logic busy;
	logic [3:0] qref;
	logic [2:0] trim;
	int mismatches = 0;
	int total_checks = 0;
	// Address table with reset values and values read back after writing all ones
	localparam logic [9:0] ADR [13] = '{`OFS_GAIN_STEP_CONFIG, `OFS_GAIN_MODE_MANUAL,
		`OFS_GAIN_LOW_THRESHOLD, `OFS_GAIN_HIGH_THRESHOLD, `OFS_APPLIED_GAIN_STATUS,
		`OFS_FREQ_OFFSET_READBACK, `OFS_OSC_BAND_OVERRIDE_VALUE, `OFS_OSC_BIAS_OVERRIDE_VALUE,
		`OFS_OSC_OVERRIDE_ENABLES, `OFS_OSC_CALIBRATION_CONFIG, `OFS_CRYSTAL_TRIM_CONFIG,
		`OFS_OSC_BAND_READBACK, 10'h100};
	localparam logic [7:0] RST [13] = '{8'h9C, 8'h00, 8'h37, 8'h69, 8'h00, 8'h00, 8'h00,
		8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00};
	localparam logic [7:0] FULL [13] = '{8'hFF, 8'h7F, 8'hFF, 8'hFF, 8'h12, 8'h0A, 8'hFF,
		8'hFF, 8'h3F, 8'h0F, 8'h38, 8'h5A, 8'h00};
	localparam logic [4:0] MAN [4] = '{5'h00, 5'h16, 5'h0D, 5'h1F};

	radio_gain_vco_cfg_regs #(.CAL_CYCLES(4)) DUT
	(
		.clk(clk), .resetn(resetn), .ce(ce), .req(req), .rdata(rdata),
		.signal_level(level), .signal_level_valid(level_valid),
		.preamble_qualified(preamble), .freq_error(ferr), .freq_error_valid(ferr_valid),
		.transmit_state_entry(tx_entry), .receive_state_entry(rx_entry),
		.band_search(band_search), .bias_search(bias_search), .applied_gain(applied_gain),
		.extra_low_amp_active(extra_low), .osc_band(osc_band), .osc_bias(osc_bias),
		.osc_q_phase_level_ref(qref), .crystal_cap_trim(trim), .osc_cal_busy(busy)
	);

	// 100 MHz clock
	always #5 clk = ~clk;

	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			mismatches++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// One-cycle write strobe; the slave never stalls
	task automatic reg_wr(input logic [9:0] a, input logic [7:0] v);
		@(posedge clk);
		req.addr <= a;
		req.wdata <= v;
		req.wr <= 1'b1;
		@(posedge clk);
		req.wr <= 1'b0;
	endtask

	// Read data is only valid in the cycle after the strobe, so sample it there
	task automatic rd_chk(input logic [9:0] a, input logic [7:0] exp);
		@(posedge clk);
		req.addr <= a;
		req.rd <= 1'b1;
		@(posedge clk);
		req.rd <= 1'b0;
		#1;
		check(rdata, exp);
	endtask

	task automatic lvl(input logic [7:0] v);
		@(posedge clk);
		level <= v;
		level_valid <= 1'b1;
		@(posedge clk);
		level_valid <= 1'b0;
		repeat (2) @(posedge clk);
		#1;
	endtask

	task automatic final_report;
		if (mismatches == 0 && total_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// Main sequence
	initial
	begin
		repeat (20) @(posedge clk);
		resetn <= 1'b1;
		for (int i = 0; i < 13; i++)
			rd_chk(ADR[i], RST[i]);
		lvl(8'h10);
		check({3'h0, applied_gain}, 8'h01);
		lvl(8'h80);
		check({3'h0, applied_gain}, 8'h00);
		lvl(8'h40);
		check({3'h0, applied_gain}, 8'h00);
		reg_wr(`OFS_GAIN_MODE_MANUAL, 8'h40);
		lvl(8'h10);
		check({3'h0, applied_gain}, 8'h00);
		reg_wr(`OFS_GAIN_MODE_MANUAL, 8'h60);
		lvl(8'h10);
		check({3'h0, applied_gain}, 8'h01);
		@(posedge clk);
		preamble <= 1'b1;
		lvl(8'h80);
		check({3'h0, applied_gain}, 8'h01);
		@(posedge clk);
		preamble <= 1'b0;
		reg_wr(`OFS_GAIN_MODE_MANUAL, 8'h00);
		lvl(8'h80);
		check({3'h0, applied_gain}, 8'h00);
		reg_wr(`OFS_GAIN_STEP_CONFIG, 8'h9E);
		lvl(8'h80);
		check({7'h0, extra_low}, 8'h01);
		reg_wr(`OFS_GAIN_STEP_CONFIG, 8'h9D);
		repeat (2) @(posedge clk);
		#1;
		check({7'h0, extra_low}, 8'h00);
		repeat (6) lvl(8'h10);
		check({3'h0, applied_gain}, 8'h12);
		// Negative then positive frequency offset
		@(posedge clk);
		ferr <= 8'hF6;
		ferr_valid <= 1'b1;
		@(posedge clk);
		ferr_valid <= 1'b0;
		rd_chk(`OFS_FREQ_OFFSET_READBACK, 8'hF6);
		@(posedge clk);
		ferr <= 8'h0A;
		ferr_valid <= 1'b1;
		@(posedge clk);
		ferr_valid <= 1'b0;
		rd_chk(`OFS_FREQ_OFFSET_READBACK, 8'h0A);
		// Calibration on transmit entry with the reset setting
		@(posedge clk);
		band_search <= 8'h5A;
		bias_search <= 8'hA5;
		tx_entry <= 1'b1;
		@(posedge clk);
		tx_entry <= 1'b0;
		#1;
		check({7'h0, busy}, 8'h01);
		repeat (8) @(posedge clk);
		#1;
		check({7'h0, busy}, 8'h00);
		check(osc_band, 8'h5A);
		check(osc_bias, 8'hA5);
		rd_chk(`OFS_OSC_BAND_READBACK, 8'h5A);
		// All ones everywhere: reserved bits clear, read-only places unchanged
		for (int i = 0; i < 13; i++)
			reg_wr(ADR[i], 8'hFF);
		for (int i = 0; i < 13; i++)
			rd_chk(ADR[i], FULL[i]);
		#1;
		check(osc_band, 8'hFF);
		check(osc_bias, 8'hFF);
		check({4'h0, qref}, 8'h0F);
		check({5'h0, trim}, 8'h07);
		@(posedge clk);
		rx_entry <= 1'b1;
		@(posedge clk);
		rx_entry <= 1'b0;
		repeat (2) @(posedge clk);
		#1;
		check({7'h0, busy}, 8'h00);
		// Writes are ignored while the clock enable is low
		@(posedge clk);
		ce <= 1'b0;
		reg_wr(`OFS_GAIN_LOW_THRESHOLD, 8'h11);
		@(posedge clk);
		ce <= 1'b1;
		rd_chk(`OFS_GAIN_LOW_THRESHOLD, 8'hFF);
		for (int i = 0; i < 4; i++)
		begin
			reg_wr(`OFS_GAIN_MODE_MANUAL, {3'h1, MAN[i]});
			repeat (2) @(posedge clk);
			#1;
			check({3'h0, applied_gain}, {3'h0, MAN[i]});
			rd_chk(`OFS_APPLIED_GAIN_STATUS, {3'h0, MAN[i]});
		end
		final_report;
	end

	// Watchdog well beyond the expected run length
	initial
	begin
		repeat (5000) @(posedge clk);
		mismatches++;
		final_report;
	end
endmodule

// ===== test/radio_gain_vco_cfg_regs_sva.sv
// Checker for the radio gain and oscillator register bank.
// Sees only top-level ports and keeps its own shadow of the writable fields its checks use.
`timescale 1ns/1ps
`include "radio_cfg_defines.svh"
module radio_gain_vco_cfg_regs_sva
#(
	parameter int CAL_CYCLES = 4
)
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic ce,
	input wire radio_cfg_pkg::reg_req_t req,
	input wire logic [7:0] rdata,
	input wire logic signal_level_valid,
	input wire logic transmit_state_entry,
	input wire logic receive_state_entry,
	input wire radio_cfg_pkg::gain_set_t applied_gain,
	input wire logic [7:0] osc_band,
	input wire logic [7:0] osc_bias,
	input wire logic [3:0] osc_q_phase_level_ref,
	input wire logic [2:0] crystal_cap_trim,
	input wire logic osc_cal_busy
);
	import radio_cfg_pkg::*;
	typedef struct packed
	{
		logic [7:0] mode;
		logic [7:0] band;
		logic [7:0] bias;
		logic [1:0] ovr;
		logic [3:0] cal;
		logic [15:0] busy_len;
	} shadow_t;
	shadow_t sh;
	shadow_t next_sh;
	logic entry;

	// ****************************************************************
	// Shadow of the fields the checks depend on
	// ****************************************************************
	assign entry = transmit_state_entry || receive_state_entry;

	// Mirrors software writes so checks need no view inside the design
	always_comb
	begin
		next_sh = sh;
		if (ce && req.wr)
		begin
			case (req.addr)
				`OFS_GAIN_MODE_MANUAL: next_sh.mode = {1'b0, req.wdata[6:0]};
				`OFS_OSC_BAND_OVERRIDE_VALUE: next_sh.band = req.wdata;
				`OFS_OSC_BIAS_OVERRIDE_VALUE: next_sh.bias = req.wdata;
				`OFS_OSC_OVERRIDE_ENABLES: next_sh.ovr = req.wdata[1:0];
				`OFS_OSC_CALIBRATION_CONFIG: next_sh.cal = req.wdata[3:0];
				default: next_sh.mode = sh.mode;
			endcase
		end
		if (ce)
			next_sh.busy_len = osc_cal_busy ? sh.busy_len + 16'h1 : 16'h0;
	end

	// Shadow register, reset to the register reset values
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			sh <= '{mode: 8'h00, band: 8'h00, bias: 8'h00, ovr: 2'h0, cal: 4'h1, busy_len: 16'h0};
		else
			sh <= next_sh;
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	// Read data lives for one cycle only
	property p_rd_idle_zero;
		ce && !req.rd |=> rdata == 8'h00;
	endproperty
	a_rd_idle_zero: assert property (p_rd_idle_zero) else $error("read data not zero");
	property p_status_rd;
		ce && req.rd && req.addr == `OFS_APPLIED_GAIN_STATUS |=> rdata == {3'h0, $past(applied_gain)};
	endproperty
	a_status_rd: assert property (p_status_rd) else $error("status differs from gain");
	property p_qref;
		ce && req.wr && req.addr == `OFS_OSC_OVERRIDE_ENABLES
			|=> osc_q_phase_level_ref == $past(req.wdata[5:2]);
	endproperty
	a_qref: assert property (p_qref) else $error("level reference wrong");
	property p_trim;
		ce && req.wr && req.addr == `OFS_CRYSTAL_TRIM_CONFIG |=> crystal_cap_trim == $past(req.wdata[5:3]);
	endproperty
	a_trim: assert property (p_trim) else $error("crystal trim wrong");
	property p_band_ovr;
		$past(ce) && $past(sh.ovr[0]) |-> osc_band == $past(sh.band);
	endproperty
	a_band_ovr: assert property (p_band_ovr) else $error("band override ignored");
	property p_bias_ovr;
		$past(ce) && $past(sh.ovr[1]) |-> osc_bias == $past(sh.bias);
	endproperty
	a_bias_ovr: assert property (p_bias_ovr) else $error("bias override ignored");
	property p_manual;
		$past(ce) && $past(sh.mode[6:5]) == 2'h1 |-> applied_gain == $past(sh.mode[4:0]);
	endproperty
	a_manual: assert property (p_manual) else $error("manual gain not applied");
	property p_hold;
		ce && signal_level_valid && sh.mode[6:5] == 2'h2 && $past(sh.mode[6:5]) == 2'h2
			|=> $stable(applied_gain);
	endproperty
	a_hold: assert property (p_hold) else $error("gain moved in hold");
	property p_cal_start;
		ce && entry && !osc_cal_busy && sh.cal != `CAL_SETTING_SKIP |=> osc_cal_busy;
	endproperty
	a_cal_start: assert property (p_cal_start) else $error("calibration not started");
	property p_cal_skip;
		ce && entry && !osc_cal_busy && sh.cal == `CAL_SETTING_SKIP |=> !osc_cal_busy;
	endproperty
	a_cal_skip: assert property (p_cal_skip) else $error("calibration not skipped");
	// The run length is counted rather than repeated, as CAL_CYCLES may be large
	property p_cal_len;
		$fell(osc_cal_busy) |-> sh.busy_len == CAL_CYCLES;
	endproperty
	a_cal_len: assert property (p_cal_len) else $error("calibration length wrong");
endmodule

bind radio_gain_vco_cfg_regs radio_gain_vco_cfg_regs_sva #(.CAL_CYCLES(CAL_CYCLES)) u_sva
(
	.clk(clk), .resetn(resetn), .ce(ce), .req(req), .rdata(rdata),
	.signal_level_valid(signal_level_valid), .transmit_state_entry(transmit_state_entry),
	.receive_state_entry(receive_state_entry), .applied_gain(applied_gain),
	.osc_band(osc_band), .osc_bias(osc_bias), .osc_q_phase_level_ref(osc_q_phase_level_ref),
	.crystal_cap_trim(crystal_cap_trim), .osc_cal_busy(osc_cal_busy)
);
